// ==== core/flash_self_program_pkg.sv ====
/*
 * Shared constants and types for the flash self-programming controller.
 * Assumes a single clock domain and a CPU core that raises one-cycle strobes
 * for store-program and load-program instructions.
 */
package flash_self_program_pkg;

    // Register map (byte address on the bus)
    localparam logic [7:0] REG_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Control register bit positions
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_REENABLE = 4;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_PAGE_WRITE = 2;
    localparam int BIT_PAGE_ERASE = 1;
    localparam int BIT_ENABLE = 0;

    // Legal patterns for the low five control bits
    localparam logic [4:0] PAT_REENABLE = 5'h11;
    localparam logic [4:0] PAT_LOCK_SET = 5'h09;
    localparam logic [4:0] PAT_PAGE_WRITE = 5'h05;
    localparam logic [4:0] PAT_PAGE_ERASE = 5'h03;
    localparam logic [4:0] PAT_LOAD = 5'h01;

    // Arming windows in clock cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;

    // Readback selectors on the low address bits
    localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
    localparam logic [1:0] SEL_LOCK = 2'h1;
    localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam logic [7:0] LOCK_KEEP_MASK = 8'hc3;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [2:0] {
        PH_IDLE = 3'h1,
        PH_ARMED = 3'h2,
        PH_BUSY = 3'h4
    } phase_type;

    // One CPU instruction request per cycle
    typedef struct packed {
        logic store_program_instruction;
        logic lpm;
        logic [15:0] z;
        logic [7:0] r0;
        logic [7:0] r1;
    } cpu_req_type;

    // Commands and status toward the flash array and core
    typedef struct packed {
        logic erase_go;
        logic write_go;
        logic cpu_halt;
        logic region_busy;
    } flash_cmd_type;

endpackage

// ==== core/flash_self_program_control.sv ====
/*
 * Flash self-programming controller: control register on AHB-Lite, store
 * command arming window, temporary page buffer, lock bits and fuse readback.
 * Assumes the flash array pulses flash_done once per erase or write started,
 * and that fuse inputs are static straps from the non-volatile array.
 */
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1 - Reset vector follows boot vector fuse
// RQ2 - Software cannot alter fuse values
// RQ3 - Ready interrupt while enable bit clear
// RQ4 - Region erase/write sets busy flag
// RQ5 - Busy clears on re-enable or load
// RQ6 - Bit five always reads zero
// RQ7 - Re-enable needs store within four cycles
// RQ8 - No re-enable while operation running
// RQ9 - Re-enable during load clears buffer
// RQ10 - Lock set programs lock from low data
// RQ11 - Lock set clears on completion/timeout
// RQ12 - Load within three cycles reads lock/fuse
// RQ13 - Page write stores buffer to page
// RQ14 - Page write bit clears when done/timeout
// RQ15 - Halt CPU for no-concurrent-read region ops
// RQ16 - Page erase erases addressed page
// RQ17 - Page erase bit clears when done/timeout
// RQ18 - Enable alone loads one buffer word
// RQ19 - Enable arms four cycles, held while busy
// RQ20 - Only five control patterns take effect
// RQ21 - Target page latched at operation start
// RQ22 - Software erases before writing same page
// RQ23 - Buffer clears; each word written once
// RQ24 - Readback selects by address low bits
// RQ25 - EEPROM write blocks programming and readback
module flash_self_program_control #(
    parameter int PAGE_WORDS = 32,
    parameter int FLASH_WORDS = 4096,
    parameter logic [15:0] BOOT_START = 16'h0c00,
    parameter logic [15:0] NO_CONCURRENT_READ_REGION_START = 16'h0c00
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU core
    input wire flash_self_program_pkg::cpu_req_type cpu,
    input wire logic global_irq_enable,
    output logic ready_irq,
    output logic [7:0] load_data,
    output logic load_valid,
    output logic [15:0] reset_vector,
    // Non-volatile straps and EEPROM status
    input wire logic boot_vector_select_fuse,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    input wire logic eeprom_busy,
    // Flash array
    input wire logic flash_done,
    input wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_index,
    output logic [15:0] buf_rd_data,
    output logic [$clog2(FLASH_WORDS)-$clog2(PAGE_WORDS)-1:0] flash_page,
    output flash_self_program_pkg::flash_cmd_type flash_cmd,
    output logic [7:0] lock_bits
);

    localparam int WB = $clog2(PAGE_WORDS);
    localparam int WA = $clog2(FLASH_WORDS);
    localparam int PB = WA - WB;

    // Refuse shapes the address split cannot serve
    if (PAGE_WORDS < 2 || (1 << WB) != PAGE_WORDS || WA > 15 || PB < 1) begin : g_bad_shape
        $error("flash_self_program_control: unsupported PAGE_WORDS or FLASH_WORDS");
    end

    typedef struct packed {
        flash_self_program_pkg::phase_type phase;
        logic irq_en;
        logic busy;
        logic reen;
        logic lock_set;
        logic pg_wrt;
        logic pg_ers;
        logic enable;
        logic [2:0] cnt;
        logic halt;
        logic erase_go;
        logic write_go;
        logic [PB-1:0] page;
        logic [7:0] lock;
        logic [7:0] load_data;
        logic load_valid;
        logic wr_pend;
        logic [31:0] rdata;
        logic [PAGE_WORDS-1:0] written;
        logic [PAGE_WORDS-1:0][15:0] pbuf;
        logic [15:0] buf_q;
        logic [15:0] reset_vector;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic ahb_take;
    logic addr_hit;
    logic [7:0] wd;
    logic pattern_ok;
    logic cmd_ok;
    logic spm_fire;
    logic lpm_fire;
    logic [WA-1:0] word_addr;
    logic target_rww;
    logic [7:0] ctrl_read;

    // Return to idle with all command bits dropped
    function automatic state_type to_idle(input state_type s);
        state_type t;
        t = s;
        t.phase = flash_self_program_pkg::PH_IDLE;
        t.reen = 1'b0;
        t.lock_set = 1'b0;
        t.pg_wrt = 1'b0;
        t.pg_ers = 1'b0;
        t.enable = 1'b0;
        t.cnt = 3'h0;
        return t;
    endfunction

    // Bus decode and request qualifiers
    always_comb begin
        ahb_take = hsel && hready && htrans == flash_self_program_pkg::HTRANS_NONSEQ;
        addr_hit = haddr == flash_self_program_pkg::REG_CONTROL_ADDR;
        wd = hwdata[7:0];
        pattern_ok = wd[4:0] == flash_self_program_pkg::PAT_REENABLE
            || wd[4:0] == flash_self_program_pkg::PAT_LOCK_SET
            || wd[4:0] == flash_self_program_pkg::PAT_PAGE_WRITE
            || wd[4:0] == flash_self_program_pkg::PAT_PAGE_ERASE
            || wd[4:0] == flash_self_program_pkg::PAT_LOAD; // RQ20
        // A running erase/write holds the enable bit, so commands are refused
        // An erase/write starting in this very cycle must not be re-armed over
        cmd_ok = pattern_ok && st_r.phase != flash_self_program_pkg::PH_BUSY
            && !(spm_fire && (st_r.pg_ers || st_r.pg_wrt))
            && !eeprom_busy; // RQ8 RQ25
        spm_fire = cpu.store_program_instruction && st_r.phase == flash_self_program_pkg::PH_ARMED
            && st_r.cnt != 3'h0 && !eeprom_busy; // RQ25
        // Load window is one cycle shorter than the store window
        lpm_fire = cpu.lpm && st_r.phase == flash_self_program_pkg::PH_ARMED
            && st_r.lock_set && st_r.cnt > (flash_self_program_pkg::STORE_WINDOW
            - flash_self_program_pkg::LOAD_WINDOW) && !eeprom_busy; // RQ12 RQ25
        word_addr = cpu.z[WA:1];
        target_rww = {{(16 - WA){1'b0}}, word_addr[WA-1:WB], {WB{1'b0}}} < NO_CONCURRENT_READ_REGION_START;
        ctrl_read = 8'h00;
        ctrl_read[flash_self_program_pkg::BIT_IRQ_EN] = st_r.irq_en;
        ctrl_read[flash_self_program_pkg::BIT_BUSY] = st_r.busy;
        ctrl_read[flash_self_program_pkg::BIT_REENABLE] = st_r.reen;
        ctrl_read[flash_self_program_pkg::BIT_LOCK_SET] = st_r.lock_set;
        ctrl_read[flash_self_program_pkg::BIT_PAGE_WRITE] = st_r.pg_wrt;
        ctrl_read[flash_self_program_pkg::BIT_PAGE_ERASE] = st_r.pg_ers;
        ctrl_read[flash_self_program_pkg::BIT_ENABLE] = st_r.enable;
    end

    // Next state: instruction handling first, a register write overrides it
    always_comb begin
        st_nxt = st_r;
        st_nxt.erase_go = 1'b0;
        st_nxt.write_go = 1'b0;
        st_nxt.load_valid = 1'b0;
        // Fuses are inputs only; nothing on the bus can reach them
        st_nxt.reset_vector = boot_vector_select_fuse ? 16'h0000 : BOOT_START; // RQ1 RQ2
        st_nxt.buf_q = st_r.pbuf[buf_rd_index];
        st_nxt.wr_pend = ahb_take && hwrite && addr_hit;
        if (ahb_take && !hwrite) begin
            // Unmapped reads answer zero; bit five is never set
            st_nxt.rdata = addr_hit ? {24'h000000, ctrl_read} : 32'h00000000; // RQ6
        end
        case (st_r.phase)
            flash_self_program_pkg::PH_ARMED: begin
                if (lpm_fire) begin
                    st_nxt = to_idle(st_nxt);
                    st_nxt.load_valid = 1'b1;
                    case (cpu.z[1:0])
                        flash_self_program_pkg::SEL_LOCK: st_nxt.load_data = st_r.lock; // RQ24
                        flash_self_program_pkg::SEL_FUSE_LOW: st_nxt.load_data = fuse_low;
                        flash_self_program_pkg::SEL_FUSE_HIGH: st_nxt.load_data = fuse_high;
                        default: st_nxt.load_data = 8'hff;
                    endcase
                end else if (spm_fire) begin
                    if (st_r.pg_ers || st_r.pg_wrt) begin
                        // Address latched so the pointer is free during the operation
                        st_nxt.phase = flash_self_program_pkg::PH_BUSY; // RQ19
                        st_nxt.cnt = 3'h0;
                        st_nxt.page = word_addr[WA-1:WB]; // RQ21 RQ13 RQ16
                        st_nxt.erase_go = st_r.pg_ers; // RQ16
                        st_nxt.write_go = st_r.pg_wrt; // RQ13
                        if (target_rww) begin
                            st_nxt.busy = 1'b1; // RQ4
                        end else begin
                            st_nxt.halt = 1'b1; // RQ15
                        end
                    end else if (st_r.reen) begin
                        st_nxt = to_idle(st_nxt);
                        st_nxt.busy = 1'b0; // RQ5 RQ7
                        st_nxt.written = '0; // RQ23
                    end else if (st_r.lock_set) begin
                        // Only boot lock bits can be programmed; 1 to 0 only
                        st_nxt = to_idle(st_nxt);
                        st_nxt.lock = st_r.lock
                            & (cpu.r0 | flash_self_program_pkg::LOCK_KEEP_MASK); // RQ10 RQ11
                    end else begin
                        st_nxt = to_idle(st_nxt);
                        st_nxt.busy = 1'b0; // RQ5
                        if (!st_r.written[word_addr[WB-1:0]]) begin
                            st_nxt.pbuf[word_addr[WB-1:0]] = {cpu.r1, cpu.r0}; // RQ18
                            st_nxt.written[word_addr[WB-1:0]] = 1'b1; // RQ23
                        end
                    end
                end else if (st_r.cnt == 3'h1) begin
                    st_nxt = to_idle(st_nxt); // RQ11 RQ14 RQ17 RQ19
                end else begin
                    st_nxt.cnt = st_r.cnt - 3'h1;
                end
            end
            flash_self_program_pkg::PH_BUSY: begin
                if (flash_done) begin
                    if (st_r.pg_wrt) begin
                        st_nxt.written = '0; // RQ23
                        st_nxt.pbuf = '0;
                    end
                    st_nxt = to_idle(st_nxt); // RQ14 RQ17
                    st_nxt.halt = 1'b0;
                end
            end
            default: begin
                st_nxt.phase = flash_self_program_pkg::PH_IDLE;
            end
        endcase
        // Data phase of a register write
        if (st_r.wr_pend) begin
            st_nxt.irq_en = wd[flash_self_program_pkg::BIT_IRQ_EN];
            if (cmd_ok) begin
                st_nxt.phase = flash_self_program_pkg::PH_ARMED;
                st_nxt.cnt = flash_self_program_pkg::STORE_WINDOW; // RQ19
                st_nxt.reen = wd[flash_self_program_pkg::BIT_REENABLE];
                st_nxt.lock_set = wd[flash_self_program_pkg::BIT_LOCK_SET];
                st_nxt.pg_wrt = wd[flash_self_program_pkg::BIT_PAGE_WRITE];
                st_nxt.pg_ers = wd[flash_self_program_pkg::BIT_PAGE_ERASE];
                st_nxt.enable = 1'b1;
                if (wd[flash_self_program_pkg::BIT_REENABLE]) begin
                    // Abort any partial load; the buffer restarts empty
                    st_nxt.written = '0; // RQ9
                    st_nxt.pbuf = '0;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.phase <= flash_self_program_pkg::PH_IDLE;
            st_r.lock <= flash_self_program_pkg::LOCK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs; the bus always answers OKAY with no wait states
    assign hreadyout = 1'b1;
    assign hresp = flash_self_program_pkg::HRESP_OKAY;
    assign hrdata = st_r.rdata;
    assign ready_irq = st_r.irq_en && global_irq_enable && !st_r.enable; // RQ3
    assign load_data = st_r.load_data;
    assign load_valid = st_r.load_valid;
    assign reset_vector = st_r.reset_vector;
    assign buf_rd_data = st_r.buf_q;
    assign flash_page = st_r.page;
    assign lock_bits = st_r.lock;
    assign flash_cmd = '{erase_go: st_r.erase_go, write_go: st_r.write_go,
        cpu_halt: st_r.halt, region_busy: st_r.busy}; // RQ15 RQ4

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    chk_reserved_zero: assert property (hrdata[5] == 1'b0) // RQ6
        else $error("reserved bit read as one");
    chk_irq_level: assert property (st_r.irq_en && global_irq_enable && !st_r.enable
        |-> ready_irq ##0 !(st_r.phase == flash_self_program_pkg::PH_BUSY)) // RQ3
        else $error("ready interrupt missing while idle");
    chk_window_expire: assert property ($rose(st_r.enable)
        ##0 (!cpu.store_program_instruction && !cpu.lpm && !st_r.wr_pend)[*4] |=> !st_r.enable) // RQ19
        else $error("store window did not close after four cycles");
    chk_busy_on_rww: assert property (spm_fire && (st_r.pg_ers || st_r.pg_wrt) && target_rww
        |=> st_r.busy && !st_r.halt && st_r.enable) // RQ4
        else $error("region busy not set on region operation");
    chk_halt_no_concurrent_read_region: assert property (spm_fire && (st_r.pg_ers || st_r.pg_wrt) && !target_rww
        |=> flash_cmd.cpu_halt throughout (!flash_done)[*1]) // RQ15
        else $error("cpu not halted for protected region");
    chk_busy_held: assert property (st_r.phase == flash_self_program_pkg::PH_BUSY
        && st_r.busy && !flash_done |=> st_r.busy && st_r.enable) // RQ8
        else $error("busy dropped during running operation");
    chk_load_clears: assert property (spm_fire && !st_r.pg_ers && !st_r.pg_wrt
        && !st_r.lock_set && !st_r.wr_pend |=> !st_r.busy && !st_r.enable) // RQ5
        else $error("buffer load did not clear busy");
    chk_bad_pattern: assert property (st_r.wr_pend && !pattern_ok
        && st_r.phase == flash_self_program_pkg::PH_IDLE |=> !st_r.enable) // RQ20
        else $error("illegal pattern armed a command");
    chk_lock_read: assert property (lpm_fire && cpu.z[1:0] == flash_self_program_pkg::SEL_LOCK
        |=> load_valid && load_data == $past(st_r.lock)) // RQ12
        else $error("lock readback wrong");
    chk_page_latch: assert property (st_r.phase == flash_self_program_pkg::PH_BUSY
        && $past(st_r.phase) == flash_self_program_pkg::PH_BUSY |-> $stable(flash_page)) // RQ21
        else $error("target page changed during operation");
    chk_reset_vec: assert property (boot_vector_select_fuse ##1 boot_vector_select_fuse
        |-> reset_vector == 16'h0000) // RQ1
        else $error("reset vector not zero with fuse unprogrammed");

    cov_erase: cover property (flash_cmd.erase_go);
    cov_write_no_concurrent_read_region: cover property (flash_cmd.write_go ##1 flash_cmd.cpu_halt);
    cov_lock_read: cover property (load_valid);
    cov_reenable: cover property (spm_fire && st_r.reen);

endmodule

`default_nettype wire

// ==== bench/cpu_core_model.sv ====
/*
 * CPU core stand-in: issues store-program and load-program strobes.
 * Assumes the controller samples strobe, pointer and data on one rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    // Clock
    input wire logic clock,
    // Instruction strobes toward the controller
    output var flash_self_program_pkg::cpu_req_type cpu
);
    initial cpu = '0;

    // One strobe after lag idle cycles; pointer and data are scrambled
    // afterwards so a controller that samples late never sees good values
    task automatic issue(input logic st, input int lag, input logic [15:0] z,
                         input logic [15:0] d);
        repeat (lag) @(posedge clock);
        @(posedge clock);
        cpu <= '{store_program_instruction: st, lpm: !st, z: z, r0: d[7:0], r1: d[15:8]};
        @(posedge clock);
        cpu <= '{store_program_instruction: 1'b0, lpm: 1'b0, z: ~z, r0: ~d[7:0], r1: ~d[15:8]};
    endtask
endmodule
`default_nettype wire

// ==== bench/flash_self_program_control_tb.sv ====
/*
 * Self-checking bench for the flash self-programming controller.
 * Assumes cpu_core_model as the CPU; the bench plays the flash array done pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_tb;
    localparam logic [15:0] BOOT = 16'h0c00;
    logic clock, rstn, hsel, hwrite, hready, hreadyout, hresp, global_irq_enable;
    logic ready_irq, load_valid, boot_vector_select_fuse, eeprom_busy, flash_done;
    logic [7:0] haddr, load_data, lock_bits, fuse_low, fuse_high;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [15:0] reset_vector, buf_rd_data;
    logic [4:0] buf_rd_index;
    logic [6:0] flash_page;
    flash_self_program_pkg::cpu_req_type cpu;
    flash_self_program_pkg::flash_cmd_type flash_cmd;
    int fail_count = 0;
    int samples_checked = 0;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    flash_self_program_control u_dut (
        .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu(cpu),
        .global_irq_enable(global_irq_enable), .ready_irq(ready_irq),
        .load_data(load_data), .load_valid(load_valid), .reset_vector(reset_vector),
        .boot_vector_select_fuse(boot_vector_select_fuse), .fuse_low(fuse_low),
        .fuse_high(fuse_high), .eeprom_busy(eeprom_busy), .flash_done(flash_done),
        .buf_rd_index(buf_rd_index), .buf_rd_data(buf_rd_data),
        .flash_page(flash_page), .flash_cmd(flash_cmd), .lock_bits(lock_bits)
    );
    cpu_core_model u_cpu (.clock(clock), .cpu(cpu));

    // Clock
    always #20 clock = ~clock;

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            $display("[FAIL] %s expected %h seen %h", what, e, got);
            fail_count++;
        end
    endtask

    // One AHB-Lite single word transfer, waiting on ready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        haddr <= a;
        hwrite <= w;
        htrans <= flash_self_program_pkg::HTRANS_NONSEQ;
        @(posedge clock);
        while (hready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clock);
        while (hready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        q = hrdata;
        if (n >= 20) fail_count++;
    endtask

    task automatic wr(input logic [7:0] d);
        bus(1'b1, 8'h00, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk("register", e, q);
    endtask

    // Buffer words come out one cycle after the index is taken
    task automatic peek(input logic [4:0] i, input logic [15:0] e);
        @(posedge clock);
        buf_rd_index <= i;
        @(posedge clock);
        @(negedge clock);
        chk("buffer word", 32'(e), 32'(buf_rd_data));
    endtask

    task automatic done_pulse;
        @(posedge clock);
        flash_done <= 1'b1;
        @(posedge clock);
        flash_done <= 1'b0;
    endtask

    task automatic do_reset;
        @(posedge clock);
        rstn <= 1'b0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        @(negedge clock);
    endtask

    task automatic t_reset;
        chk("vector", 32'h0, 32'(reset_vector));
        chk("lock", 32'hff, 32'(lock_bits));
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        wr(8'hff);
        rd(8'h00, 32'h80);
        chk("vector", 32'h0, 32'(reset_vector));
        boot_vector_select_fuse <= 1'b0;
        do_reset;
        chk("vector", 32'(BOOT), 32'(reset_vector));
        $display("t_reset done");
    endtask

    task automatic t_irq;
        @(posedge clock);
        global_irq_enable <= 1'b1;
        wr(8'h80);
        @(negedge clock);
        chk("irq", 32'h1, 32'(ready_irq));
        wr(8'h81);
        @(negedge clock);
        chk("irq", 32'h0, 32'(ready_irq));
        repeat (6) @(posedge clock);
        rd(8'h00, 32'h80);
        global_irq_enable <= 1'b0;
        wr(8'h00);
        rd(8'h00, 32'h0);
        $display("t_irq done");
    endtask

    task automatic t_load;
        wr(8'h01);
        u_cpu.issue(1'b1, 0, 16'h0006, 16'hbeef);
        peek(5'h3, 16'hbeef);
        wr(8'h01);
        u_cpu.issue(1'b1, 0, 16'h0007, 16'h1234);
        peek(5'h3, 16'hbeef);
        wr(8'h01);
        u_cpu.issue(1'b1, 3, 16'h0008, 16'h4321);
        peek(5'h4, 16'h0);
        rd(8'h00, 32'h0);
        $display("t_load done");
    endtask

    task automatic t_erase;
        wr(8'h03);
        u_cpu.issue(1'b1, 0, 16'h0140, 16'hffff);
        @(negedge clock);
        chk("erase go", 32'h1, 32'(flash_cmd.erase_go));
        chk("busy", 32'h1, 32'(flash_cmd.region_busy));
        chk("halt", 32'h0, 32'(flash_cmd.cpu_halt));
        wr(8'h11);
        u_cpu.issue(1'b1, 0, 16'h0000, 16'h0);
        rd(8'h00, 32'h43);
        chk("page", 32'h5, 32'(flash_page));
        done_pulse;
        rd(8'h00, 32'h40);
        wr(8'h01);
        u_cpu.issue(1'b1, 0, 16'h0004, 16'h5a5a);
        rd(8'h00, 32'h0);
        wr(8'h11);
        peek(5'h2, 16'h0);
        wr(8'h03);
        u_cpu.issue(1'b1, 0, 16'h0180, 16'h0);
        done_pulse;
        rd(8'h00, 32'h40);
        wr(8'h11);
        u_cpu.issue(1'b1, 2, 16'h0000, 16'h0);
        rd(8'h00, 32'h0);
        $display("t_erase done");
    endtask

    task automatic t_no_concurrent_read_region;
        wr(8'h03);
        u_cpu.issue(1'b1, 0, 16'h1900, 16'h0);
        @(negedge clock);
        chk("halt", 32'h1, 32'(flash_cmd.cpu_halt));
        chk("busy", 32'h0, 32'(flash_cmd.region_busy));
        done_pulse;
        wr(8'h01);
        u_cpu.issue(1'b1, 0, 16'h1902, 16'hc0de);
        peek(5'h1, 16'hc0de);
        wr(8'h05);
        u_cpu.issue(1'b1, 0, 16'h1900, 16'h0);
        @(negedge clock);
        chk("write go", 32'h1, 32'(flash_cmd.write_go));
        chk("halt", 32'h1, 32'(flash_cmd.cpu_halt));
        chk("page", 32'h64, 32'(flash_page));
        done_pulse;
        rd(8'h00, 32'h0);
        peek(5'h1, 16'h0);
        wr(8'h05);
        repeat (6) @(posedge clock);
        rd(8'h00, 32'h0);
        $display("t_no_concurrent_read_region done");
    endtask

    task automatic t_lock;
        logic [15:0] sel [3] = '{16'h0000, 16'h0001, 16'h0003};
        logic [7:0] want [3];
        want = '{fuse_low, 8'hf3, fuse_high};
        wr(8'h09);
        u_cpu.issue(1'b1, 0, 16'h0001, 16'h00f3);
        @(negedge clock);
        chk("lock", 32'hf3, 32'(lock_bits));
        rd(8'h00, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(8'h09);
            u_cpu.issue(1'b0, 0, sel[i], 16'h0);
            @(negedge clock);
            chk("readback", 32'(want[i]), 32'(load_data));
            chk("load valid", 32'h1, 32'(load_valid));
        end
        wr(8'h09);
        repeat (6) @(posedge clock);
        rd(8'h00, 32'h0);
        $display("t_lock done");
    endtask

    task automatic t_eeprom;
        eeprom_busy <= 1'b1;
        wr(8'h01);
        rd(8'h00, 32'h0);
        wr(8'h09);
        u_cpu.issue(1'b0, 0, 16'h0001, 16'h0);
        @(negedge clock);
        chk("load valid", 32'h0, 32'(load_valid));
        @(posedge clock);
        eeprom_busy <= 1'b0;
        $display("t_eeprom done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence; fuse straps hold arbitrary patterns
    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        hsel = 1'b1;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        global_irq_enable = 1'b0;
        boot_vector_select_fuse = 1'b1;
        fuse_low = 8'h5c;
        fuse_high = 8'hd9;
        eeprom_busy = 1'b0;
        flash_done = 1'b0;
        buf_rd_index = 5'h0;
        do_reset;
        t_reset;
        t_irq;
        t_load;
        t_erase;
        t_no_concurrent_read_region;
        t_lock;
        t_eeprom;
        report_and_stop;
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge clock);
        fail_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
